// ---- src/flash_host_ctrl.sv ----
// host-side controller driving a parallel flash through its bus pins
// assumes the flash pins are sampled synchronously to i_clk; the data
// bus wire is resolved outside from o_data_pins and o_data_pins_oe
`timescale 1ns/1ns
`default_nettype none
module flash_host_ctrl
    import flash_host_pkg::*;
(
    // clock, async active-low reset, clock enable
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // user request side
    input wire logic i_req,
    input wire op_t i_op,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_byte_mode,
    input wire logic i_powerdown,
    output logic o_ack,
    output logic o_busy,
    output logic [DATA_W-1:0] o_rdata,
    // flash pins
    output logic o_reset_powerdown_n,
    output logic o_chip_enable_a_n,
    output logic o_chip_enable_b_n,
    output logic o_oe_n,
    output logic o_we_n,
    output logic o_byte_n,
    output logic [ADDR_W-1:0] o_addr,
    output logic [DATA_W-1:0] o_data_pins,
    output logic o_data_pins_oe,
    input wire logic [DATA_W-1:0] i_data_pins
);

    typedef struct packed {
        state_t st;
        mode_t mode;
        op_t op;
        logic byte_mode;
        logic [ADDR_W-1:0] addr;
        logic [7:0] cmd;
        logic [DATA_W-1:0] rdata;
        logic ack;
        logic busy;
        logic rp_n;
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic byte_n;
        logic [ADDR_W-1:0] pin_addr;
        logic [DATA_W-1:0] dout;
        logic doe;
    } ctrl_t;

    ctrl_t q;
    ctrl_t nxt;
    logic rst_meta_ff;
    logic rst_n;
    logic tmr_start;
    logic [TIMER_W-1:0] tmr_load;
    logic tmr_done;
    logic need_cmd;
    logic [7:0] req_cmd;

    // reset release through two flops; assertion is immediate
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n <= rst_meta_ff;
        end
    end

    flash_host_timer u_timer (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_ce(i_ce),
        .i_start(tmr_start),
        .i_load(tmr_load),
        .o_done(tmr_done)
    );

    // query offsets sit one pin up in both widths, so A0 stays low there
    function automatic logic [ADDR_W-1:0] map_addr(input op_t op,
            input logic byte_mode, input logic [ADDR_W-1:0] addr);
        if (byte_mode && op != OP_QUERY) begin
            map_addr = addr;
        end else begin
            map_addr = {addr[ADDR_W-2:0], 1'b0};
        end
    endfunction : map_addr

    // command needed for a request; a mode already held needs none
    always_comb begin
        req_cmd = CMD_READ_ARRAY;
        need_cmd = 1'b1;
        case (i_op)
            OP_ARRAY: begin
                need_cmd = (q.mode != MODE_ARRAY);
            end
            OP_IDENT: begin
                req_cmd = CMD_READ_IDENT;
                need_cmd = (q.mode != MODE_IDENT);
            end
            OP_STATUS: begin
                req_cmd = CMD_READ_STATUS;
                need_cmd = (q.mode != MODE_STATUS);
            end
            OP_EXT_STATUS: begin
                req_cmd = CMD_MULTI_WRITE; // every read reissues it
            end
            OP_QUERY: begin
                req_cmd = CMD_QUERY;
                need_cmd = (q.mode != MODE_QUERY);
            end
            OP_CLEAR: begin
                req_cmd = CMD_CLEAR_STATUS; // only sticky drop
            end
            OP_WRITE: begin
                req_cmd = i_wdata[7:0];
            end
            default: begin
                req_cmd = CMD_READ_ARRAY;
            end
        endcase
    end

    // sequencer: every pin phase is timed by the shared down counter
    always_comb begin
        nxt = q;
        nxt.ack = 1'b0;
        tmr_start = 1'b0;
        tmr_load = '0;
        case (q.st)
            ST_START: begin
                tmr_start = 1'b1;
                tmr_load = PD_CYC - ONE_CYC;
                nxt.st = ST_DOWN;
            end
            ST_DOWN: begin
                // reset pin stays low for the whole power-down spell
                if (tmr_done && !i_powerdown) begin
                    nxt.rp_n = 1'b1;
                    tmr_start = 1'b1;
                    tmr_load = WAKE_CYC - ONE_CYC;
                    nxt.st = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (tmr_done) begin
                    nxt.mode = MODE_ARRAY; // no command needed on wake
                    nxt.st = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (i_powerdown) begin
                    nxt.rp_n = 1'b0;
                    tmr_start = 1'b1;
                    tmr_load = PD_CYC - ONE_CYC;
                    nxt.st = ST_DOWN;
                end else if (i_req) begin
                    nxt.op = i_op;
                    nxt.byte_mode = i_byte_mode;
                    nxt.byte_n = !i_byte_mode;
                    nxt.addr = i_addr;
                    nxt.cmd = req_cmd;
                    nxt.pin_addr = map_addr(i_op, i_byte_mode, i_addr);
                    nxt.ce_n = 1'b0;
                    tmr_start = 1'b1;
                    if (need_cmd) begin
                        nxt.we_n = 1'b0;
                        nxt.dout = (i_op == OP_WRITE) ? i_wdata :
                            {BYTE_ZERO, req_cmd};
                        nxt.doe = 1'b1;
                        tmr_load = WE_CYC - ONE_CYC;
                        nxt.st = ST_WR_LOW;
                    end else begin
                        nxt.oe_n = 1'b0;
                        tmr_load = ACC_CYC - ONE_CYC;
                        nxt.st = ST_RD_LOW;
                    end
                end
            end
            ST_WR_LOW: begin
                // flash latches address and data on this rising edge
                if (tmr_done) begin
                    nxt.we_n = 1'b1;
                    nxt.ce_n = 1'b1;
                    tmr_start = 1'b1;
                    tmr_load = REC_CYC - ONE_CYC;
                    nxt.st = ST_WR_HIGH;
                end
            end
            ST_WR_HIGH: begin
                if (tmr_done) begin
                    nxt.doe = 1'b0;
                    case (q.op)
                        OP_ARRAY: nxt.mode = MODE_ARRAY;
                        OP_IDENT: nxt.mode = MODE_IDENT;
                        OP_STATUS: nxt.mode = MODE_STATUS;
                        OP_QUERY: nxt.mode = MODE_QUERY;
                        // F8H leaves no held mode, a busy flash may have dropped 50H, and a
                        // raw write may start anything: trust no mode
                        default: nxt.mode = MODE_OTHER;
                    endcase
                    if (q.op == OP_CLEAR || q.op == OP_WRITE) begin
                        nxt.ack = 1'b1;
                        nxt.st = ST_IDLE;
                    end else begin
                        nxt.ce_n = 1'b0;
                        nxt.oe_n = 1'b0;
                        tmr_start = 1'b1;
                        tmr_load = ACC_CYC - ONE_CYC;
                        nxt.st = ST_RD_LOW;
                    end
                end
            end
            ST_RD_LOW: begin
                if (tmr_done) begin
                    // low lane only; empty query bytes pass as zero
                    if (q.byte_mode || q.op == OP_QUERY) begin
                        nxt.rdata = {BYTE_ZERO, i_data_pins[7:0]};
                    end else begin
                        nxt.rdata = i_data_pins;
                    end
                    nxt.oe_n = 1'b1; // release so the next read relatches
                    nxt.ce_n = 1'b1;
                    tmr_start = 1'b1;
                    tmr_load = REC_CYC - ONE_CYC;
                    nxt.st = ST_RD_HIGH;
                end
            end
            ST_RD_HIGH: begin
                if (tmr_done) begin
                    nxt.ack = 1'b1;
                    nxt.st = ST_IDLE;
                end
            end
            default: begin
                nxt.st = ST_START;
            end
        endcase
        nxt.busy = (nxt.st != ST_IDLE);
    end

    // state register; i_ce low freezes the sequencer and its timer
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            q.st <= ST_START;
            q.mode <= MODE_OTHER;
            q.op <= OP_ARRAY;
            q.busy <= 1'b1;
            q.ce_n <= 1'b1;
            q.oe_n <= 1'b1;
            q.we_n <= 1'b1;
            q.byte_n <= 1'b1;
        end else if (i_ce) begin
            q <= nxt;
        end
    end

    assign o_ack = q.ack;
    assign o_busy = q.busy;
    assign o_rdata = q.rdata;
    assign o_reset_powerdown_n = q.rp_n;
    assign o_chip_enable_a_n = q.ce_n;
    assign o_chip_enable_b_n = q.ce_n;
    assign o_oe_n = q.oe_n;
    assign o_we_n = q.we_n;
    assign o_byte_n = q.byte_n;
    assign o_addr = q.pin_addr;
    assign o_data_pins = q.dout;
    assign o_data_pins_oe = q.doe;

    // helper counters for pulse-width checks
    logic [TIMER_W-1:0] we_low_cnt;
    logic [TIMER_W-1:0] oe_low_cnt;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            we_low_cnt <= '0;
            oe_low_cnt <= '0;
        end else begin
            we_low_cnt <= o_we_n ? '0 : we_low_cnt + ONE_CYC;
            oe_low_cnt <= o_oe_n ? '0 : oe_low_cnt + ONE_CYC;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!rst_n);

    sequence s_write_end;
        $rose(o_we_n);
    endsequence
    sequence s_read_start;
        $fell(o_oe_n);
    endsequence

    property p_we_width;
        s_write_end |-> we_low_cnt >= WE_CYC;
    endproperty
    a_we_width: assert property (p_we_width)
        else $error("write pulse too short");

    property p_data_hold;
        s_write_end |-> o_data_pins_oe;
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("data released before write edge");

    property p_no_overlap;
        !(!o_oe_n && !o_we_n);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("output and write enables low together");

    property p_rp_high;
        (!o_we_n || !o_oe_n) |-> o_reset_powerdown_n;
    endproperty
    a_rp_high: assert property (p_rp_high)
        else $error("bus cycle with reset pin low");

    property p_read_width;
        $rose(o_oe_n) |-> oe_low_cnt >= ACC_CYC && !o_data_pins_oe;
    endproperty
    a_read_width: assert property (p_read_width)
        else $error("read strobe shorter than access time");

    property p_oe_release;
        $rose(o_oe_n) |-> o_oe_n[*5];
    endproperty
    a_oe_release: assert property (p_oe_release)
        else $error("enable not held high before next read");

    property p_ext_reissue;
        (s_read_start ##0 (q.op == OP_EXT_STATUS))
            |-> q.cmd == CMD_MULTI_WRITE && $past(q.st) == ST_WR_HIGH;
    endproperty
    a_ext_reissue: assert property (p_ext_reissue)
        else $error("extended status read without fresh command");

    property p_query_a0;
        (!o_oe_n && q.op == OP_QUERY) |-> !o_addr[0];
    endproperty
    a_query_a0: assert property (p_query_a0)
        else $error("query read with low address bit set");

    property p_query_upper;
        (o_ack && q.op == OP_QUERY) |-> o_rdata[15:8] == BYTE_ZERO;
    endproperty
    a_query_upper: assert property (p_query_upper)
        else $error("query upper byte not zero");

    property p_wake_mode;
        ($past(q.st) == ST_WAKE && q.st == ST_IDLE) |-> q.mode == MODE_ARRAY;
    endproperty
    a_wake_mode: assert property (p_wake_mode)
        else $error("wake did not assume array mode");

endmodule : flash_host_ctrl
`default_nettype wire

// ---- src/flash_host_pkg.sv ----
// constants and types shared by the parallel flash read-mode controller
// assumes a 250 MHz system clock and a flash with 21 address pins, 16 data
package flash_host_pkg;

    // bus widths of the flash side
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int TIMER_W = 8;

    // command codes placed on the low data byte during a write cycle
    localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
    localparam logic [7:0] CMD_READ_IDENT = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_MULTI_WRITE = 8'hF8;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
    localparam logic [7:0] CMD_QUERY = 8'h98;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // pin timing, times in ns, counts rounded up to whole clocks
    localparam int CLK_NS = 4;
    localparam int T_WE_NS = 50;
    localparam int T_ACC_NS = 120;
    localparam int T_REC_NS = 20;
    localparam int T_PD_NS = 100;
    localparam int T_WAKE_NS = 1000;
    localparam logic [TIMER_W-1:0] WE_CYC =
        TIMER_W'((T_WE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TIMER_W-1:0] ACC_CYC =
        TIMER_W'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TIMER_W-1:0] REC_CYC =
        TIMER_W'((T_REC_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TIMER_W-1:0] PD_CYC =
        TIMER_W'((T_PD_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TIMER_W-1:0] WAKE_CYC =
        TIMER_W'((T_WAKE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [TIMER_W-1:0] ONE_CYC = 8'h01;

    // user operations
    typedef enum logic [2:0] {
        OP_ARRAY, OP_IDENT, OP_STATUS, OP_EXT_STATUS,
        OP_QUERY, OP_CLEAR, OP_WRITE
    } op_t;

    // read mode the flash is believed to be in
    typedef enum logic [2:0] {
        MODE_ARRAY, MODE_IDENT, MODE_STATUS, MODE_QUERY, MODE_OTHER
    } mode_t;

    // sequencer states
    typedef enum logic [3:0] {
        ST_START, ST_DOWN, ST_WAKE, ST_IDLE,
        ST_WR_LOW, ST_WR_HIGH, ST_RD_LOW, ST_RD_HIGH
    } state_t;

endpackage : flash_host_pkg

// ---- src/flash_host_timer.sv ----
// down counter that times each pin phase of the flash sequencer
// assumes the caller loads phase length minus one and waits for done
`timescale 1ns/1ns
`default_nettype none
module flash_host_timer
    import flash_host_pkg::*;
(
    // clock, reset and clock enable
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // control
    input wire logic i_start,
    input wire logic [TIMER_W-1:0] i_load,
    output logic o_done
);

    typedef struct packed {
        logic [TIMER_W-1:0] cnt;
    } tmr_t;

    tmr_t q;
    tmr_t nxt;

    // load on start, else run down to zero and stop there
    always_comb begin
        nxt = q;
        if (i_start) begin
            nxt.cnt = i_load;
        end else if (q.cnt != '0) begin
            nxt.cnt = q.cnt - ONE_CYC;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            q <= '0;
        end else if (i_ce) begin
            q <= nxt;
        end
    end

    assign o_done = (q.cnt == '0);

endmodule : flash_host_timer
`default_nettype wire

// ---- tb/flash_dev_model.sv ----
// behavioural parallel flash: read modes, status latches, query bytes
// assumes a host on the pins; i_wsm_busy and i_fail_set come from the bench
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model #(
    parameter logic [15:0] MAKER_CODE = 16'h005A, // arbitrary value
    parameter logic [15:0] DEVICE_CODE = 16'h00C3 // arbitrary value
) (
    // host pins
    input wire logic i_clk,
    input wire logic i_rp_n,
    input wire logic i_ce_a_n,
    input wire logic i_ce_b_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_byte_n,
    input wire logic [20:0] i_addr,
    input wire logic [15:0] i_din,
    // bench controls
    input wire logic i_wsm_busy,
    input wire logic i_fail_set,
    output logic [15:0] o_dout
);
    logic [2:0] mode_ff = 3'h0; // 0 array 1 id 2 status 3 ext 4 query
    logic [7:0] set_cnt_ff = 8'h00; // failures seen
    logic [7:0] clr_cnt_ff = 8'h00; // failures cleared so far
    logic [7:0] ext_cnt_ff = 8'h00;
    logic [7:0] ext_lat_ff = 8'h00;
    logic [15:0] stat_lat_ff = 16'h0000;
    logic [15:0] val;
    wire rd = i_rp_n && !i_ce_a_n && !i_ce_b_n && !i_oe_n;
    wire fail = (set_cnt_ff != clr_cnt_ff); // sticky bits 5,4,3,1
    wire [7:0] sr = {~i_wsm_busy, 1'b0, {3{fail}}, 1'b0, fail, 1'b0};

    // command decode on write-enable rise; power-down restores array
    always @(posedge i_we_n or negedge i_rp_n) begin
        if (!i_rp_n) begin
            mode_ff <= 3'h0;
        end else begin
            case (i_din[7:0])
                8'hFF: if (!i_wsm_busy) mode_ff <= 3'h0;
                8'h90: mode_ff <= 3'h1;
                8'h70: mode_ff <= 3'h2;
                8'hF8: begin
                    mode_ff <= 3'h3;
                    ext_cnt_ff <= ext_cnt_ff + 8'h01;
                end
                8'h98: mode_ff <= 3'h4;
                8'h50: if (!i_wsm_busy) begin
                    clr_cnt_ff <= set_cnt_ff;
                end
                default: ; // unknown codes change nothing
            endcase
        end
    end

    // failures are sticky until cleared
    always @(posedge i_fail_set) begin
        set_cnt_ff <= set_cnt_ff + 8'h01;
    end

    // latches load when the last enable falls
    always @(posedge rd) begin
        stat_lat_ff <= {8'h00, sr};
        ext_lat_ff <= ext_cnt_ff;
    end

    // read data by mode
    always_comb begin
        case (mode_ff)
            3'h1: begin
                case (i_addr[15:1]) // upper bits pick the block
                    15'h0: val = MAKER_CODE;
                    15'h1: val = DEVICE_CODE;
                    15'h2: val = {14'h0, i_addr[17:16]};
                    default: val = 16'h0000;
                endcase
            end
            3'h2: val = stat_lat_ff;
            3'h3: val = {8'h00, ext_lat_ff};
            3'h4: begin
                case (i_addr[20:1]) // a0 dropped, x8 pairs repeat
                    20'h10: val = 16'h0051;
                    20'h11: val = 16'h0052;
                    20'h12: val = 16'h0059;
                    20'h13: val = 16'h0001;
                    default: val = 16'h0000;
                endcase
            end
            default: val = i_addr[15:0] ^ 16'h3C5A;
        endcase
    end

    // released lanes toggle so a stale value never reads as valid
    initial o_dout = 16'h5A5A;
    always @(posedge i_clk) begin
        o_dout[7:0] <= rd ? val[7:0] : ~o_dout[7:0];
        o_dout[15:8] <= (rd && i_byte_n) ? val[15:8] : ~o_dout[15:8];
    end
endmodule : flash_dev_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench for the flash read-mode controller
// assumes the behavioural flash model on the pins, one 250 MHz clock
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import flash_host_pkg::*;
    localparam logic [15:0] MAKER = 16'h005A; // arbitrary value
    localparam logic [15:0] DEVICE = 16'h00C3; // arbitrary value
    logic i_clk, i_arst_n, i_req, i_byte_mode, i_powerdown;
    op_t i_op;
    logic [ADDR_W-1:0] i_addr, f_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata, f_dout, f_din, dev_out;
    logic o_ack, o_busy, rp_n, ce_a_n, ce_b_n, oe_n, we_n, byte_n, f_doe;
    logic wsm_busy, fail_set;
    logic [16:0] exp_q[$];
    logic [16:0] note;
    logic [31:0] rng = 32'h783C;
    int failures = 0;
    int total_checks = 0;
    int k;

    // host drives the bus while enabled, else the flash
    assign f_din = f_doe ? f_dout : dev_out;

    flash_host_ctrl i_flash_host_ctrl (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(1'b1),
        .i_req(i_req), .i_op(i_op), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_byte_mode(i_byte_mode), .i_powerdown(i_powerdown),
        .o_ack(o_ack), .o_busy(o_busy), .o_rdata(o_rdata),
        .o_reset_powerdown_n(rp_n), .o_chip_enable_a_n(ce_a_n),
        .o_chip_enable_b_n(ce_b_n), .o_oe_n(oe_n), .o_we_n(we_n),
        .o_byte_n(byte_n), .o_addr(f_addr), .o_data_pins(f_dout),
        .o_data_pins_oe(f_doe), .i_data_pins(f_din));

    flash_dev_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE))
    i_flash_dev_model (
        .i_clk(i_clk), .i_rp_n(rp_n), .i_ce_a_n(ce_a_n), .i_ce_b_n(ce_b_n),
        .i_oe_n(oe_n), .i_we_n(we_n), .i_byte_n(byte_n), .i_addr(f_addr),
        .i_din(f_din), .i_wsm_busy(wsm_busy), .i_fail_set(fail_set),
        .o_dout(dev_out));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    // array pattern as the flash stores it, seen through the width
    function automatic logic [15:0] arr(input logic [20:0] a, input logic bm);
        logic [15:0] w;
        w = (bm ? a[15:0] : {a[14:0], 1'b0}) ^ 16'h3C5A;
        return bm ? {8'h00, w[7:0]} : w;
    endfunction : arr

    task automatic chk16(input string nm, input logic [15:0] e,
            input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk16

    // waits for an idle controller, returns on a rising edge
    task automatic wait_idle;
        do @(negedge i_clk); while (o_busy !== 1'b0);
        @(posedge i_clk);
    endtask : wait_idle

    // one request, taken on the first idle edge; result noted in order
    task automatic run_op(input op_t o, input logic [20:0] a,
            input logic bm, input logic [15:0] wd, input logic [16:0] n);
        wait_idle();
        i_req <= 1'b1;
        i_op <= o;
        i_addr <= a;
        i_byte_mode <= bm;
        i_wdata <= wd;
        exp_q.push_back(n);
        @(posedge i_clk);
        i_req <= 1'b0;
    endtask : run_op

    task automatic rd(input op_t o, input logic [20:0] a, input logic bm,
            input logic [15:0] e);
        run_op(o, a, bm, 16'h0000, {1'b1, e});
    endtask : rd

    task automatic wr(input op_t o, input logic [15:0] wd);
        run_op(o, 21'h0, 1'b0, wd, 17'h0);
    endtask : wr

    // failures only between transfers, so an open read is not disturbed
    task automatic pulse_fail;
        wait_idle();
        fail_set <= 1'b1;
        @(posedge i_clk);
        fail_set <= 1'b0;
    endtask : pulse_fail

    // busy flag moves only once the previous transfer has finished
    task automatic set_busy(input logic b);
        wait_idle();
        wsm_busy <= b;
    endtask : set_busy

    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end

    // watcher: each acknowledged read result against the oldest note
    always @(negedge i_clk) begin
        if (o_ack === 1'b1) begin
            note = exp_q.pop_front();
            if (note[16]) chk16("o_rdata", note[15:0], o_rdata);
        end
    end

    // hang guard, well above the few thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge i_clk);
        failures++;
        conclude();
    end

    initial begin
        {i_arst_n, i_req, i_byte_mode, i_powerdown} = 4'h0;
        {wsm_busy, fail_set} = 2'h0;
        i_op = OP_ARRAY;
        i_addr = 21'h0;
        i_wdata = 16'h0;
        repeat (20) @(posedge i_clk);
        i_arst_n <= 1'b1;
        rd(OP_ARRAY, 21'h00123, 1'b0, arr(21'h00123, 1'b0));
        for (k = 0; k < 6; k++) begin
            rng = xs(rng);
            rd(OP_ARRAY, rng[20:0], rng[21], arr(rng[20:0], rng[21]));
        end
        rd(OP_IDENT, 21'h0, 1'b0, MAKER);
        rd(OP_IDENT, 21'h1, 1'b1, {8'h00, MAKER[7:0]});
        rd(OP_IDENT, 21'h1, 1'b0, DEVICE);
        for (k = 0; k < 4; k++) begin
            rd(OP_IDENT, {k[5:0], 15'h2}, 1'b0, 16'(k));
            rd(OP_IDENT, {k[4:0], 16'h5}, 1'b1, 16'(k));
        end
        pulse_fail();
        rd(OP_STATUS, 21'h0, 1'b0, 16'h00BA);
        set_busy(1'b1);
        wr(OP_CLEAR, 16'h0);
        rd(OP_STATUS, 21'h0, 1'b0, 16'h003A);
        set_busy(1'b0);
        wr(OP_CLEAR, 16'h0);
        rd(OP_STATUS, 21'h0, 1'b0, 16'h0080);
        pulse_fail();
        rd(OP_STATUS, 21'h0, 1'b0, 16'h00BA);
        rd(OP_EXT_STATUS, 21'h0, 1'b0, 16'h0001);
        rd(OP_ARRAY, 21'h00040, 1'b0, arr(21'h00040, 1'b0));
        rd(OP_EXT_STATUS, 21'h0, 1'b0, 16'h0002);
        wr(OP_WRITE, 16'h00AB);
        for (k = 0; k < 2; k++) begin
            rd(OP_QUERY, 21'h10, k[0], 16'h0051);
            rd(OP_QUERY, 21'h12, k[0], 16'h0059);
            rd(OP_QUERY, 21'h13, k[0], 16'h0001);
            rd(OP_QUERY, 21'h05, k[0], 16'h0000);
        end
        wait_idle();
        i_powerdown <= 1'b1;
        for (k = 0; k < 100 && rp_n !== 1'b0; k++) @(negedge i_clk);
        chk16("rp_n", 16'h0, {15'h0, rp_n});
        @(posedge i_clk);
        i_powerdown <= 1'b0;
        rd(OP_ARRAY, 21'h00077, 1'b0, arr(21'h00077, 1'b0));
        for (k = 0; k < 500 && exp_q.size() != 0; k++) @(negedge i_clk);
        if (exp_q.size() != 0) failures++; // unanswered requests
        conclude();
    end
endmodule : tb_top
`default_nettype wire
